// ---- stop_eval_pkg.sv ----
package stop_eval_pkg;

  // ------------------------------------------------------------
  // register map (apb byte addresses)
  // ------------------------------------------------------------
  localparam logic [7:0] addr_ctrl = 8'h00;
  localparam logic [7:0] addr_std_cfg = 8'h04;
  localparam logic [7:0] addr_adv_enable = 8'h08;
  localparam logic [7:0] addr_adv_state = 8'h0c;
  localparam logic [7:0] addr_status = 8'h10;
  localparam logic [7:0] addr_trig_pos = 8'h14;

  // ------------------------------------------------------------
  // field positions and reset values
  // ------------------------------------------------------------
  localparam int ctrl_adv_bit = 0;
  localparam int std_state_lsb = 8;
  localparam int toggle_bit = 15;
  localparam logic [7:0] std_code_reset = 8'h00;
  localparam logic [1:0] std_state_reset = 2'h0;
  localparam logic [15:0] word_reset = 16'h0000;
  localparam logic [31:0] pos_reset = 32'h00000000;

  // stop state encodings
  localparam logic [1:0] st_false = 2'h0;
  localparam logic [1:0] st_true = 2'h1;
  localparam logic [1:0] st_fall = 2'h2;
  localparam logic [1:0] st_rise = 2'h3;

  // ------------------------------------------------------------
  // check stage sequence
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    stage_idle,
    stage_second,
    stage_last,
    stage_done
  } stage_e;

endpackage : stop_eval_pkg

// ---- motion_stop_condition_evaluator.sv ----
// Contract
// - source code zero: no input checking, move runs to its end
// - codes -1..-7 input lines, -8 reserved, -9/-10 internal/external index
// - codes -11..-14 moving err, holding err, trajectory active, delay active
// - state 0 false, 1 true, 2 falling, 3 rising
// - edge states compare successive samples, not levels
// - advanced mode checks only index and input lines one to three
// - enable bit arms a source, same state bit gives its condition
// - bits 14:12 first check; any hit at start reverses direction
// - reversed plus toggle bit inverts enabled second-check conditions
// - reversed plus toggle-or bit inverts enabled last-check or conditions
// - first check once at start, then straight to second check
// - last check waits until second-check conditions are met
// - second check never met: move completes normally
// - or only: stop on any enabled condition
// - several and conditions: stop only when all hold
// - single and condition only: record position, no stop
// - and plus or: combine results with and, stop if true
// - stop starts deceleration at detection with move acceleration
// - trigger captures current position into trigger register
// - bit 15 of each word holds a toggle flag, used on reversal
//
// Design decisions made here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
module motion_stop_condition_evaluator #(
  parameter int pos_width = 32
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic move_start,
  input wire logic move_active,
  input wire logic [6:0] io_lines,
  input wire logic internal_index,
  input wire logic external_index,
  input wire logic moving_error,
  input wire logic holding_error,
  input wire logic traj_active,
  input wire logic delay_active,
  input wire logic [pos_width-1:0] current_pos,
  output logic reverse_dir,
  output logic stop_req,
  output logic capture_strobe
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  typedef struct packed {
    // configuration written over the bus
    logic adv_mode;
    logic [7:0] std_code;
    logic [1:0] std_state;
    logic [15:0] en_word;
    logic [15:0] st_word;
    // sampling and move progress, restarted on move_start except trig_pos, which keeps its value
    logic [13:0] src_prev;
    logic prev_valid;
    stop_eval_pkg::stage_e stage;
    logic reversed;
    logic [pos_width-1:0] trig_pos;
    logic stopped;
    logic captured;
    // one-cycle outputs and latched read data
    logic stop_pulse;
    logic cap_pulse;
    logic [31:0] rdata;
  } state_s;

  state_s s_reg;
  state_s s_next;

  // condition test on one source; edge needs a valid previous sample
  function automatic logic cond_met(input logic [1:0] st, input logic cur, input logic prv,
                                    input logic pv);
    // levels look only at the current sample
    case (st)
      stop_eval_pkg::st_false: cond_met = !cur;
      stop_eval_pkg::st_true: cond_met = cur;
      stop_eval_pkg::st_fall: cond_met = pv && prv && !cur;
      default: cond_met = pv && !prv && cur;
    endcase
  endfunction : cond_met

  // ------------------------------------------------------------
  // sources and combinational evaluation
  // ------------------------------------------------------------
  logic [13:0] src_now;
  logic [3:0] adv_now;
  logic [3:0] adv_prev;
  // per-source hits of each check
  logic [3:0] first_hit;
  logic [3:0] second_hit;
  logic [3:0] and_hit;
  logic [3:0] or_hit;
  // check summaries and bus strobes
  logic std_hit;
  logic last_hit;
  logic last_stop;
  logic wr_en;
  logic rd_en;
  logic [4:0] code_idx;

  // index 0..13 maps codes -1..-14; -8 tied low as reserved
  assign src_now = {delay_active, traj_active, holding_error, moving_error,
                    external_index, internal_index, 1'b0, io_lines};
  // advanced set is index plus lines one to three only
  assign adv_now = {internal_index, io_lines[2:0]};
  assign adv_prev = {s_reg.src_prev[8], s_reg.src_prev[2:0]};
  // code -n picks source n-1; negating and stepping down is just the inverse
  assign code_idx = 5'(8'h00 - s_reg.std_code - 8'h01);

  // one slice per advanced source: bit 3 is the index, bits 2:0 lines three to one
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_adv
      // first check uses bits 14:12 (lines) ; bit 15 is the toggle flag
      if (g < 3) begin : g_first
        assign first_hit[g] = s_reg.en_word[12+g] &&
          cond_met({1'b0, s_reg.st_word[12+g]}, adv_now[g], adv_prev[g], s_reg.prev_valid);
      end else begin : g_nofirst
        assign first_hit[g] = 1'b0;
      end
      // second check, inverted on reversal when toggle flag set
      assign second_hit[g] = cond_met({1'b0, s_reg.st_word[8+g] ^ (s_reg.reversed &&
        s_reg.en_word[stop_eval_pkg::toggle_bit])}, adv_now[g], adv_prev[g], s_reg.prev_valid);
      assign and_hit[g] = cond_met({1'b0, s_reg.st_word[4+g]}, adv_now[g], adv_prev[g],
                                   s_reg.prev_valid);
      // or conditions in the low nibble, invertible on reversal
      assign or_hit[g] = cond_met({1'b0, s_reg.st_word[g] ^ (s_reg.reversed &&
        s_reg.st_word[stop_eval_pkg::toggle_bit])}, adv_now[g], adv_prev[g], s_reg.prev_valid);
    end
  endgenerate

  // ------------------------------------------------------------
  // check summaries
  // ------------------------------------------------------------
  // standard hit and last-check verdict; stop and record differ only for one and
  always_comb begin
    logic and_any;
    logic or_any;
    logic and_all;
    logic or_one;
    logic and_single;
    // which sets of the last check are armed
    and_any = |s_reg.en_word[7:4];
    or_any = |s_reg.en_word[3:0];
    and_all = &(and_hit | ~s_reg.en_word[7:4]);
    or_one = |(or_hit & s_reg.en_word[3:0]);
    and_single = $countones(s_reg.en_word[7:4]) == 1;
    // standard form: selected source against the state code
    // only codes -1..-14 name a source; -8 and stray positive codes never fire
    if (s_reg.std_code == stop_eval_pkg::std_code_reset || s_reg.std_code[7:4] != 4'hf ||
        code_idx > 5'd13 || code_idx == 5'd7) begin
      std_hit = 1'b0;
    end else begin
      std_hit = cond_met(s_reg.std_state, src_now[code_idx[3:0]],
                         s_reg.src_prev[code_idx[3:0]], s_reg.prev_valid);
    end
    // last check: and-set and or-set combined with and when both armed
    if (and_any && or_any) begin
      last_hit = and_all && or_one;
      last_stop = last_hit;
    end else if (or_any) begin
      last_hit = or_one;
      last_stop = last_hit;
    end else if (and_any) begin
      last_hit = and_all;
      last_stop = last_hit && !and_single;
    end else begin
      last_hit = 1'b0;
      last_stop = 1'b0;
    end
  end

  // ------------------------------------------------------------
  // bus strobes
  // ------------------------------------------------------------
  // writes land in the access cycle; reads are latched in setup so prdata is
  // already settled when the zero-wait access phase ends
  assign wr_en = psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  // one pass per cycle: hold everything, drop the pulses, then apply events
  always_comb begin
    s_next = s_reg;
    // outputs are one-cycle pulses unless set again below
    s_next.stop_pulse = 1'b0;
    s_next.cap_pulse = 1'b0;
    // samples taken every cycle for edge detection
    s_next.src_prev = src_now;
    s_next.prev_valid = 1'b1;
    if (move_start) begin
      // fresh move: clear stage state; first check evaluated only here
      s_next.stopped = 1'b0;
      s_next.captured = 1'b0;
      s_next.prev_valid = 1'b0;
      if (s_reg.adv_mode) begin
        s_next.reversed = |first_hit;
        s_next.stage = stop_eval_pkg::stage_second;
      end else begin
        s_next.reversed = 1'b0;
        s_next.stage = stop_eval_pkg::stage_idle;
      end
    end else if (move_active && !s_reg.stopped) begin
      // checks run only inside a move and rest after the first stop
      if (!s_reg.adv_mode) begin
        // standard form stops and records in the same cycle
        if (std_hit) begin
          s_next.stopped = 1'b1;
          s_next.stop_pulse = 1'b1;
          s_next.cap_pulse = 1'b1;
          s_next.trig_pos = current_pos;
        end
      end else begin
        case (s_reg.stage)
          stop_eval_pkg::stage_second: begin
            // stays here for the whole move if never satisfied
            if (&(second_hit | ~s_reg.en_word[11:8])) begin
              s_next.stage = stop_eval_pkg::stage_last;
            end
          end
          stop_eval_pkg::stage_last: begin
            // record once per move, even when a single and never stops
            if (last_hit && !s_reg.captured) begin
              s_next.trig_pos = current_pos;
              s_next.cap_pulse = 1'b1;
              s_next.captured = 1'b1;
            end
            if (last_stop) begin
              s_next.stopped = 1'b1;
              s_next.stop_pulse = 1'b1;
              s_next.stage = stop_eval_pkg::stage_done;
            end
          end
          stop_eval_pkg::stage_done: s_next.stage = stop_eval_pkg::stage_done;
          default: s_next.stage = s_reg.stage;
        endcase
      end
    end
    // register writes take effect at the access edge
    if (wr_en) begin
      case (paddr)
        stop_eval_pkg::addr_ctrl: s_next.adv_mode = pwdata[stop_eval_pkg::ctrl_adv_bit];
        stop_eval_pkg::addr_std_cfg: begin
          s_next.std_code = pwdata[7:0];
          s_next.std_state = pwdata[stop_eval_pkg::std_state_lsb +: 2];
        end
        stop_eval_pkg::addr_adv_enable: s_next.en_word = pwdata[15:0];
        stop_eval_pkg::addr_adv_state: s_next.st_word = pwdata[15:0];
        default: s_next.adv_mode = s_next.adv_mode;
      endcase
    end
    // read data captured in setup, presented in access
    if (rd_en) begin
      case (paddr)
        stop_eval_pkg::addr_ctrl: s_next.rdata = {31'h0, s_reg.adv_mode};
        stop_eval_pkg::addr_std_cfg: s_next.rdata = {22'h0, s_reg.std_state, s_reg.std_code};
        stop_eval_pkg::addr_adv_enable: s_next.rdata = {16'h0, s_reg.en_word};
        stop_eval_pkg::addr_adv_state: s_next.rdata = {16'h0, s_reg.st_word};
        stop_eval_pkg::addr_status: s_next.rdata = {26'h0, s_reg.captured, s_reg.stopped,
                                                     s_reg.reversed, 1'b0, s_reg.stage};
        stop_eval_pkg::addr_trig_pos: s_next.rdata = 32'(s_reg.trig_pos);
        default: s_next.rdata = 32'h00000000;
      endcase
    end
  end

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  // whole state in one register; reset leaves every stage idle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // zero-wait apb slave; unmapped reads return zero
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign prdata = s_reg.rdata;

  // motion outputs straight from flops so the trajectory side sees no glitch
  assign reverse_dir = s_reg.reversed;
  assign stop_req = s_reg.stop_pulse;
  assign capture_strobe = s_reg.cap_pulse;

endmodule : motion_stop_condition_evaluator

// ---- stop_eval_checker.sv ----
`timescale 1ns/10ps
module stop_eval_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic move_start,
  input wire logic move_active,
  input wire logic reverse_dir,
  input wire logic stop_req,
  input wire logic capture_strobe
);
  // ------------------------------------------------------------
  // output timing rules
  // ------------------------------------------------------------
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  // a second stop in one move would jerk the axis
  a_stop_once: assert property (stop_req |=> !stop_req [*8])
    else $error("stop request repeated");
  a_cap_pulse: assert property (capture_strobe |=> !capture_strobe)
    else $error("capture strobe too long");
  a_stop_in_move: assert property (stop_req |-> $past(move_active))
    else $error("stop outside a move");
  a_cap_in_move: assert property (capture_strobe |-> $past(move_active))
    else $error("capture outside a move");
  a_stop_records: assert property (stop_req |-> capture_strobe)
    else $error("stop without captured position");
  a_rev_at_start: assert property ($changed(reverse_dir) |-> $past(move_start))
    else $error("direction changed mid move");
  a_no_stop_start: assert property (move_start |-> !stop_req)
    else $error("stop left over from last move");
  a_apb_answer: assert property (psel && penable |-> pready && !pslverr)
    else $error("bus access not answered");
endmodule : stop_eval_checker

// ---- move_model.sv ----
`timescale 1ns/10ps
module move_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic go,
  input wire logic stop_req,
  output logic move_start,
  output logic move_active,
  output logic [31:0] current_pos
);
  logic [5:0] left;
  // trajectory side: fixed length move, short tail after a stop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      move_start <= 1'b0;
      move_active <= 1'b0;
      left <= 6'h00;
      current_pos <= 32'h00000100;
    end else begin
      move_start <= go;
      if (go) begin
        move_active <= 1'b1;
        left <= 6'h1e;
      end else if (left == 6'h00) begin
        move_active <= 1'b0;
      end else begin
        left <= stop_req ? 6'h02 : left - 6'h01; // decel tail
      end
      if (move_active) current_pos <= current_pos + 32'h00000001;
    end
  end
endmodule : move_model

// ---- motion_stop_condition_evaluator_bench.sv ----
`timescale 1ns/10ps
module motion_stop_condition_evaluator_bench;
  // ------------------------------------------------------------
  // clock, reset, design and partner
  // ------------------------------------------------------------
  logic pclk, presetn, psel, penable, pwrite, go, move_start, move_active;
  logic reverse_dir, stop_req, capture_strobe, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, current_pos, q;
  logic [12:0] src; // delay,traj,hold,moving,ext,int,io7..io1
  int fail_count, total_checks;
  always #25 pclk = ~pclk;
  motion_stop_condition_evaluator uut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .move_start(move_start), .move_active(move_active),
    .io_lines(src[6:0]), .internal_index(src[7]), .external_index(src[8]),
    .moving_error(src[9]), .holding_error(src[10]), .traj_active(src[11]),
    .delay_active(src[12]), .current_pos(current_pos), .reverse_dir(reverse_dir),
    .stop_req(stop_req), .capture_strobe(capture_strobe));
  move_model partner (.pclk(pclk), .presetn(presetn), .go(go), .stop_req(stop_req),
    .move_start(move_start), .move_active(move_active), .current_pos(current_pos));
  // ------------------------------------------------------------
  // bus, compare and move tasks
  // ------------------------------------------------------------
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // one move: flags are reverse, stop, capture
  task automatic run(input logic [12:0] pre, input logic [12:0] post, input logic [2:0] e);
    logic [2:0] f;
    logic [31:0] p;
    logic [31:0] pp;
    p = 32'h00000000;
    @(posedge pclk);
    src <= pre;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    repeat (4) @(posedge pclk);
    src <= post;
    #1 f = {reverse_dir, 2'h0};
    // pp is the position in the cycle before each edge, the one a trigger records
    repeat (12) begin
      pp = current_pos;
      @(posedge pclk) #1;
      f = f | {reverse_dir, stop_req, capture_strobe};
      if (capture_strobe) p = pp;
    end
    while (move_active) @(posedge pclk);
    chk({29'h0, f}, {29'h0, e});
    xfer(1'b0, stop_eval_pkg::addr_trig_pos, 32'h0);
    if (e[0]) chk(q, p);
  endtask : run
  task automatic adv(input logic [15:0] en, input logic [15:0] st);
    xfer(1'b1, stop_eval_pkg::addr_ctrl, 32'h00000001);
    xfer(1'b1, stop_eval_pkg::addr_adv_enable, {16'h0000, en});
    xfer(1'b1, stop_eval_pkg::addr_adv_state, {16'h0000, st});
  endtask : adv
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_std;
    logic [12:0] b;
    xfer(1'b0, stop_eval_pkg::addr_adv_enable, 32'h0);
    chk(q, 32'h00000000);
    xfer(1'b0, 8'hfc, 32'h0);
    chk(q, 32'h00000000);
    xfer(1'b1, stop_eval_pkg::addr_std_cfg, 32'h00000100);
    run(13'h0000, 13'h1fff, 3'h0);
    for (int k = 1; k <= 14; k++) begin
      b = k == 8 ? 13'h1fff : 13'h0001 << (k < 8 ? k - 1 : k - 2);
      xfer(1'b1, stop_eval_pkg::addr_std_cfg, {24'h000001, 8'h00 - k[7:0]});
      run(13'h0000, b, k == 8 ? 3'h0 : 3'h3);
    end
    for (int s = 0; s < 4; s++) begin
      xfer(1'b1, stop_eval_pkg::addr_std_cfg, {22'h0, s[1:0], 8'hff});
      run(s[0] ? 13'h0 : 13'h1, s[0] ? 13'h1 : 13'h0, 3'h3);
    end
    run(13'h0001, 13'h0001, 3'h0);
    $display("standard stop test done");
  endtask : t_std
  task automatic t_adv;
    adv(16'h0001, 16'h0001);
    run(13'h0000, 13'h0001, 3'h3);
    adv(16'h0030, 16'h0030);
    run(13'h0000, 13'h0001, 3'h0);
    run(13'h0000, 13'h0003, 3'h3);
    adv(16'h0010, 16'h0010);
    run(13'h0000, 13'h0001, 3'h1);
    adv(16'h0012, 16'h0012);
    run(13'h0000, 13'h0003, 3'h3);
    adv(16'h0201, 16'h0201);
    run(13'h0000, 13'h0001, 3'h0);
    adv(16'h9102, 16'h1102);
    run(13'h0001, 13'h0002, 3'h7);
    adv(16'h1102, 16'h1102);
    run(13'h0000, 13'h0003, 3'h3);
    adv(16'h1008, 16'h9008);
    run(13'h0081, 13'h0000, 3'h7);
    xfer(1'b0, stop_eval_pkg::addr_status, 32'h0);
    chk(q, 32'h0000003b);
    xfer(1'b0, stop_eval_pkg::addr_adv_state, 32'h0);
    chk(q, 32'h00009008);
    $display("advanced stop test done");
  endtask : t_adv
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_of_test
  // main sequence and watchdog
  initial begin
    {pclk, presetn, psel, penable, pwrite, go, paddr, pwdata, src} = '0;
    fail_count = 0;
    total_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_std;
    t_adv;
    end_of_test;
  end
  initial begin
    #2000000;
    fail_count++;
    end_of_test;
  end
endmodule : motion_stop_condition_evaluator_bench
bind motion_stop_condition_evaluator stop_eval_checker chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .move_start(move_start), .move_active(move_active), .reverse_dir(reverse_dir),
  .stop_req(stop_req), .capture_strobe(capture_strobe));
